// [drd_top.sv]
// Purpose: Debug resource decoder, run control and lookup table
// Assumes: Access address is in the sys_clk_i domain; halt request is not
// Notes: Outputs are registered, so selects follow the address by one cycle
`timescale 1ns/1ps

// Contract
// - Low three windows to trace, watch, breakpoint
// - Control space mapped, sub-blocks routed separately
// - Trace port window reserved when shared
// - Next window goes to program trace
// - Implementation range; top window is table
// - Each component one aligned 4KB window
// - Decode only inside private peripheral region
// - Flag shows debug state while halted
// - Software trace only with main extension
// - Trace configurations need a trace sink
// - Synchronise async external halt, then halt
// - Halt control bit halts the element
// - Step and resume, optional interrupt masking
// - Core register access only while halted
// - Table lists only implemented components
// - Table ends with all-zero entry
module drd_top
    import drd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Access path
    input wire logic acc_valid_i,
    input wire logic [31:0] acc_addr_i,
    // Configuration straps
    input wire logic main_ext_i,
    input wire logic tpu_shared_i,
    input wire logic ext_sink_i,
    input wire logic ptu_present_i,
    // Run control
    input wire logic ext_halt_req_i,
    input wire logic halt_cmd_i,
    input wire logic step_cmd_i,
    input wire logic resume_cmd_i,
    input wire logic mask_int_i,
    input wire logic step_done_i,
    input wire logic reg_req_i,
    // Decoded selects
    output logic [DRD_SEL_W-1:0] sel_o,
    output logic [31:0] lut_data_o,
    // Run state and trace flags
    output logic debug_state_o,
    output logic halt_o,
    output logic int_mask_o,
    output logic reg_grant_o,
    output logic trace_en_o,
    output logic dwt_trace_en_o,
    output logic sink_ok_o
);

    // ------------------------------------------------------------
    // Window decode
    // ------------------------------------------------------------
    drd_sel_if dec_bus ();
    assign dec_bus.valid = acc_valid_i;
    assign dec_bus.addr = acc_addr_i;

    drd_window_decode i_drd_window_decode (
        .bus(dec_bus.decoder),
        .main_ext_i(main_ext_i),
        .tpu_shared_i(tpu_shared_i)
    );

    // Registered so the selects never glitch, at one cycle of latency
    // reserved and unlisted give zero
    logic [DRD_SEL_W-1:0] sel_reg;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_reg <= '0;
        end else begin
            sel_reg <= dec_bus.sel;
        end
    end
    // Port straight from its flop
    assign sel_o = sel_reg;

    // ------------------------------------------------------------
    // Lookup table
    // ------------------------------------------------------------
    // Entry presence per slot; slot order matches select order
    wire tpu_local = !tpu_shared_i;
    wire [DRD_LUT_ENTRIES-1:0] present;
    assign present[0] = main_ext_i;
    assign present[1] = 1'b1;
    assign present[2] = 1'b1;
    assign present[3] = 1'b1;
    assign present[4] = tpu_local;
    assign present[5] = ptu_present_i;
    assign present[6] = 1'b0;
    assign present[7] = 1'b0;

    // Offsets are negative relative to the table base
    logic [31:0] lut_offs [DRD_LUT_ENTRIES];
    wire [31:0] lut_comp [DRD_LUT_ENTRIES];
    assign lut_comp[0] = DRD_SWT_BASE;
    assign lut_comp[1] = DRD_WDT_BASE;
    assign lut_comp[2] = DRD_BPU_BASE;
    // Control space page stands for both of its sub-blocks
    assign lut_comp[3] = DRD_SCS_FIRST & DRD_WIN_MASK;
    assign lut_comp[4] = DRD_TPU_BASE;
    assign lut_comp[5] = DRD_PTU_BASE;
    // Spare slots in this build
    assign lut_comp[6] = DRD_LUT_END;
    assign lut_comp[7] = DRD_LUT_END;

    // Compact present entries to the front so no gaps appear
    // A walker stops at the first zero, so a hole would hide later parts
    logic [31:0] lut_rows [DRD_LUT_ENTRIES];
    always_comb begin
        int n;
        n = 0;
        for (int k = 0; k < DRD_LUT_ENTRIES; k++) begin
            lut_rows[k] = DRD_LUT_END;
        end
        for (int k = 0; k < DRD_LUT_ENTRIES; k++) begin
            if (present[k]) begin
                lut_rows[n[DRD_LUT_IDX_W-1:0]] = ((lut_comp[k] - DRD_LUT_BASE) & DRD_WIN_MASK)
                    | DRD_LUT_PRESENT;
                n = n + 1;
            end
        end
    end

    // One copy per table slot
    genvar gi;
    generate
        for (gi = 0; gi < DRD_LUT_ENTRIES; gi++) begin : g_offs
            assign lut_offs[gi] = lut_rows[gi];
        end
    endgenerate

    // Index from word address inside the table window; byte lanes are ignored
    wire [DRD_LUT_IDX_W-1:0] lut_idx = acc_addr_i[DRD_LUT_IDX_LSB +: DRD_LUT_IDX_W];
    // Words past the last slot read as the end marker
    wire lut_in_rows = (acc_addr_i & ~DRD_WIN_MASK) < (32'(DRD_LUT_ENTRIES) << DRD_LUT_IDX_LSB);
    wire [31:0] lut_word = (dec_bus.sel[DRD_SEL_LUT] && lut_in_rows) ? lut_offs[lut_idx] : DRD_LUT_END;

    logic [31:0] lut_data_reg;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lut_data_reg <= DRD_LUT_END;
        end else begin
            lut_data_reg <= lut_word;
        end
    end
    // Table word leaves from its own flop
    assign lut_data_o = lut_data_reg;

    // ------------------------------------------------------------
    // External halt synchroniser
    // ------------------------------------------------------------
    // Three stages; a change counts once stages two and three agree
    // Only the second stage reads the first, so a metastable value never fans out
    logic sync1_reg, sync2_reg, sync3_reg, ext_halt_reg;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= ext_halt_req_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Hold the last agreed level while the two late stages disagree
    wire agree = (sync2_reg == sync3_reg);
    wire ext_halt_next = agree ? sync3_reg : ext_halt_reg;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_halt_reg <= 1'b0;
        end else begin
            ext_halt_reg <= ext_halt_next;
        end
    end
    // Rising edge of the filtered level requests one halt
    // A request held high halts once, so resume still works under it
    wire ext_halt_rise = ext_halt_next && !ext_halt_reg;

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    // Run control state and latched mask
    drd_state_e state_reg, state_next;
    logic mask_reg, mask_next;

    // Halt sources; a halt command wins over step or resume in the same cycle
    wire halt_any = halt_cmd_i || ext_halt_rise;

    // Next state decode
    always_comb begin
        state_next = state_reg;
        mask_next = mask_reg;
        case (state_reg)
            DRD_RUN: begin
                if (halt_any) begin
                    state_next = DRD_HALTED;
                end
            end
            DRD_HALTED: begin
                // step or resume
                // Mask is latched with the command and kept until the next one
                if (halt_cmd_i) begin
                    state_next = DRD_HALTED;
                end else if (step_cmd_i) begin
                    state_next = DRD_STEP;
                    mask_next = mask_int_i;
                end else if (resume_cmd_i) begin
                    state_next = DRD_RUN;
                    mask_next = mask_int_i;
                end
            end
            DRD_STEP: begin
                // One instruction, then back to halted
                // A halt during the step also lands in halted
                if (step_done_i || halt_any) begin
                    state_next = DRD_HALTED;
                end
            end
            // Unused code parks in halted, the safe place
            default: begin
                state_next = DRD_HALTED;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= DRD_RUN;
            mask_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mask_reg <= mask_next;
        end
    end

    // Registered status outputs
    // Look ahead one state so the flags change with the state itself
    wire halted_next = (state_next == DRD_HALTED);
    logic debug_state_reg, halt_reg, int_mask_reg, reg_grant_reg;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            debug_state_reg <= 1'b0;
            halt_reg <= 1'b0;
            int_mask_reg <= 1'b0;
            reg_grant_reg <= 1'b0;
        end else begin
            debug_state_reg <= halted_next;
            halt_reg <= (state_next != DRD_RUN) && (state_next != DRD_STEP);
            // Masking only matters while executing
            int_mask_reg <= mask_next && (state_next != DRD_HALTED);
            // access only when halted
            // Halted in both cycles, so a resume cuts the grant at once
            reg_grant_reg <= reg_req_i && halted_next && (state_reg == DRD_HALTED);
        end
    end
    // Ports straight from their flops
    assign debug_state_o = debug_state_reg;
    assign halt_o = halt_reg;
    assign int_mask_o = int_mask_reg;
    assign reg_grant_o = reg_grant_reg;

    // ------------------------------------------------------------
    // Trace configuration
    // ------------------------------------------------------------
    // A sink exists when the local unit is private or an outside one is wired
    // Straps are static; the flops only keep the outputs registered
    wire sink_there = tpu_local || ext_sink_i;
    logic trace_en_reg, dwt_trace_en_reg, sink_ok_reg;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trace_en_reg <= 1'b0;
            dwt_trace_en_reg <= 1'b0;
            sink_ok_reg <= 1'b0;
        end else begin
            trace_en_reg <= main_ext_i && sink_there;
            dwt_trace_en_reg <= main_ext_i && sink_there;
            sink_ok_reg <= sink_there;
        end
    end
    // Trace flags straight from their flops
    assign trace_en_o = trace_en_reg;
    assign dwt_trace_en_o = dwt_trace_en_reg;
    assign sink_ok_o = sink_ok_reg;

endmodule // drd_top

// [drd_pkg.sv]
// Purpose: Shared constants and types for the debug resource decoder
// Assumes: 32-bit byte addresses on the access path
// Notes: Window bases and masks are named here once
package drd_pkg;

    // ------------------------------------------------------------
    // Address windows
    // ------------------------------------------------------------
    localparam logic [31:0] DRD_PPB_BASE = 32'hE000_0000;
    localparam logic [31:0] DRD_PPB_LAST = 32'hE00F_FFFF;
    localparam logic [31:0] DRD_WIN_MASK = 32'hFFFF_F000;
    localparam logic [31:0] DRD_SWT_BASE = 32'hE000_0000;
    localparam logic [31:0] DRD_WDT_BASE = 32'hE000_1000;
    localparam logic [31:0] DRD_BPU_BASE = 32'hE000_2000;
    localparam logic [31:0] DRD_SCS_FIRST = 32'hE000_ED00;
    localparam logic [31:0] DRD_SCS_LAST = 32'hE000_EFFF;
    localparam logic [31:0] DRD_SCB_LAST = 32'hE000_ED8F;
    localparam logic [31:0] DRD_DCB_FIRST = 32'hE000_EDF0;
    localparam logic [31:0] DRD_DCB_LAST = 32'hE000_EEFF;
    localparam logic [31:0] DRD_TPU_BASE = 32'hE004_0000;
    localparam logic [31:0] DRD_PTU_BASE = 32'hE004_1000;
    localparam logic [31:0] DRD_IMP_FIRST = 32'hE004_2000;
    localparam logic [31:0] DRD_IMP_LAST = 32'hE00F_EFFF;
    localparam logic [31:0] DRD_LUT_BASE = 32'hE00F_F000;

    // ------------------------------------------------------------
    // Lookup table layout
    // ------------------------------------------------------------
    localparam logic [31:0] DRD_LUT_END = 32'h0000_0000;
    localparam logic [31:0] DRD_LUT_PRESENT = 32'h0000_0001;
    localparam int DRD_LUT_ENTRIES = 8;
    localparam int DRD_LUT_IDX_W = 3;
    localparam int DRD_LUT_IDX_LSB = 2;

    // Select vector bit positions
    localparam int DRD_SEL_SWT = 0;
    localparam int DRD_SEL_WDT = 1;
    localparam int DRD_SEL_BPU = 2;
    localparam int DRD_SEL_SCB = 3;
    localparam int DRD_SEL_DCB = 4;
    localparam int DRD_SEL_SCS = 5;
    localparam int DRD_SEL_TPU = 6;
    localparam int DRD_SEL_PTU = 7;
    localparam int DRD_SEL_IMP = 8;
    localparam int DRD_SEL_LUT = 9;
    localparam int DRD_SEL_W = 10;

    typedef logic [DRD_SEL_W-1:0] drd_sel_t;

    // Run control states
    typedef enum logic [1:0] {
        DRD_RUN = 2'b00,
        DRD_HALTED = 2'b01,
        DRD_STEP = 2'b10
    } drd_state_e;

endpackage

// [drd_sel_if.sv]
// Purpose: Carries the decoded select vector between decoder modules
// Assumes: Single clock domain
// Notes: Decoder drives, control module consumes
`timescale 1ns/1ps
interface drd_sel_if;
    import drd_pkg::*;
    logic valid;
    logic [31:0] addr;
    drd_sel_t sel;
    modport decoder (input valid, input addr, output sel);
    modport user (output valid, output addr, input sel);
endinterface

// [drd_window_decode.sv]
// Purpose: Combinational window decoder for the debug resources
// Assumes: Configuration straps are stable while accesses are made
// Notes: One-hot select, all zero on a miss or reserved window
`timescale 1ns/1ps
module drd_window_decode
    import drd_pkg::*;
(
    // Select carrier
    drd_sel_if.decoder bus,
    // Configuration
    input wire logic main_ext_i,
    input wire logic tpu_shared_i
);

    // ------------------------------------------------------------
    // Region tests
    // ------------------------------------------------------------
    wire [31:0] page = bus.addr & DRD_WIN_MASK;
    wire in_ppb = bus.valid && (bus.addr >= DRD_PPB_BASE) && (bus.addr <= DRD_PPB_LAST);
    wire hit_swt = in_ppb && (page == DRD_SWT_BASE);
    wire hit_wdt = in_ppb && (page == DRD_WDT_BASE);
    wire hit_bpu = in_ppb && (page == DRD_BPU_BASE);
    wire hit_tpu = in_ppb && (page == DRD_TPU_BASE);
    wire hit_ptu = in_ppb && (page == DRD_PTU_BASE);
    wire hit_lut = in_ppb && (page == DRD_LUT_BASE);
    wire hit_scs = in_ppb && (bus.addr >= DRD_SCS_FIRST) && (bus.addr <= DRD_SCS_LAST);
    wire hit_scb = hit_scs && (bus.addr <= DRD_SCB_LAST);
    wire hit_dcb = hit_scs && (bus.addr >= DRD_DCB_FIRST) && (bus.addr <= DRD_DCB_LAST);
    wire hit_imp = in_ppb && (bus.addr >= DRD_IMP_FIRST) && (bus.addr <= DRD_IMP_LAST);

    // Assemble the select vector
    // low three windows
    assign bus.sel[DRD_SEL_SWT] = hit_swt && main_ext_i;
    assign bus.sel[DRD_SEL_WDT] = hit_wdt;
    assign bus.sel[DRD_SEL_BPU] = hit_bpu;
    assign bus.sel[DRD_SEL_SCB] = hit_scb;
    assign bus.sel[DRD_SEL_DCB] = hit_dcb;
    assign bus.sel[DRD_SEL_SCS] = hit_scs && !hit_scb && !hit_dcb;
    assign bus.sel[DRD_SEL_TPU] = hit_tpu && !tpu_shared_i;
    assign bus.sel[DRD_SEL_PTU] = hit_ptu;
    assign bus.sel[DRD_SEL_IMP] = hit_imp;
    assign bus.sel[DRD_SEL_LUT] = hit_lut;

endmodule // drd_window_decode

// [drd_monitor.sv]
// Purpose: Bound checker for decode and run control of drd_top
// Assumes: Straps change only while reset is low
// Notes: Selects and run state are registered, one edge behind their cause
`timescale 1ns/1ps
module drd_monitor
    import drd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Inputs watched
    input wire logic acc_valid_i,
    input wire logic [31:0] acc_addr_i,
    input wire logic main_ext_i,
    input wire logic tpu_shared_i,
    input wire logic ext_sink_i,
    input wire logic ext_halt_req_i,
    input wire logic halt_cmd_i,
    input wire logic step_cmd_i,
    input wire logic mask_int_i,
    input wire logic reg_req_i,
    // Outputs watched
    input wire logic [DRD_SEL_W-1:0] sel_o,
    input wire logic [31:0] lut_data_o,
    input wire logic debug_state_o,
    input wire logic halt_o,
    input wire logic int_mask_o,
    input wire logic reg_grant_o,
    input wire logic trace_en_o,
    input wire logic dwt_trace_en_o,
    input wire logic sink_ok_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Valid folded in, so a stale address on an idle bus never matches a page
    wire logic [31:0] acc_page = acc_valid_i ? (acc_addr_i & DRD_WIN_MASK) : 32'h0000_0000;
    wire logic in_scb = acc_valid_i && acc_addr_i >= DRD_SCS_FIRST && acc_addr_i <= DRD_SCB_LAST;
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_bpu_window: assert property (acc_page == DRD_BPU_BASE |=> sel_o == drd_sel_t'(1 << DRD_SEL_BPU))
        else $error("breakpoint window not selected");
    a_scb_range: assert property (in_scb |=> sel_o == drd_sel_t'(1 << DRD_SEL_SCB))
        else $error("control block range not selected");
    a_tpu_shared: assert property (acc_page == DRD_TPU_BASE && tpu_shared_i |=> sel_o == '0)
        else $error("shared trace port window selected");
    a_ptu_window: assert property (acc_page == DRD_PTU_BASE |=> sel_o == drd_sel_t'(1 << DRD_SEL_PTU))
        else $error("program trace window not selected");
    a_sel_onehot: assert property ($onehot0(sel_o))
        else $error("more than one select");
    a_outside_region: assert property (acc_valid_i && !(acc_addr_i inside {[DRD_PPB_BASE:DRD_PPB_LAST]})
        |=> sel_o == '0)
        else $error("select outside region");
    a_halt_flag: assert property (debug_state_o == halt_o)
        else $error("halt and debug state differ");
    a_swt_absent: assert property (!main_ext_i && acc_page == DRD_SWT_BASE
        |=> sel_o == '0 && !trace_en_o && !dwt_trace_en_o)
        else $error("trace present without extension");
    a_sink_needed: assert property (sink_ok_o |-> !tpu_shared_i || ext_sink_i)
        else $error("sink claimed without one");
    a_ext_halt: assert property ($rose(ext_halt_req_i) ##1 ext_halt_req_i [*3] |-> ##[0:5] debug_state_o)
        else $error("external halt not taken");
    a_halt_cmd: assert property (halt_cmd_i |=> debug_state_o)
        else $error("halt command not taken");
    a_step_mask: assert property (debug_state_o && step_cmd_i && !halt_cmd_i
        |=> !debug_state_o && int_mask_o == $past(mask_int_i))
        else $error("step not started as asked");
    a_grant_halted: assert property (reg_grant_o |-> debug_state_o && $past(reg_req_i))
        else $error("register grant while running");
    a_lut_zero: assert property (!sel_o[DRD_SEL_LUT] |-> lut_data_o == DRD_LUT_END)
        else $error("table word outside table");
endmodule // drd_monitor

bind drd_top drd_monitor i_drd_monitor (.sys_clk_i, .rst_n_i, .acc_valid_i, .acc_addr_i, .main_ext_i,
    .tpu_shared_i, .ext_sink_i, .ext_halt_req_i, .halt_cmd_i, .step_cmd_i, .mask_int_i, .reg_req_i, .sel_o,
    .lut_data_o, .debug_state_o, .halt_o, .int_mask_o, .reg_grant_o, .trace_en_o, .dwt_trace_en_o, .sink_ok_o);

// [drd_master_model.sv]
// Purpose: Bus master and halt source facing the decoder
// Assumes: Tasks are entered just after a rising edge
// Notes: Released address is inverted so stale values never decode by luck
`timescale 1ns/1ps
module drd_master_model (
    // Clock
    input wire logic sys_clk_i,
    // Access path and halt request
    output logic acc_valid_o,
    output logic [31:0] acc_addr_o,
    output logic ext_halt_req_o
);
    // Idle values at time zero
    initial begin
        acc_valid_o = 1'b0;
        acc_addr_o = 32'h0000_0000;
        ext_halt_req_o = 1'b0;
    end
    // One address per sampling edge, back to back
    task automatic access(input logic [31:0] a);
        acc_valid_o = 1'b1;
        acc_addr_o = a;
        @(posedge sys_clk_i);
        #1;
    endtask
    // Release the path for one edge
    task automatic idle;
        acc_valid_o = 1'b0;
        acc_addr_o = ~acc_addr_o;
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic ext_halt(input int n);
        ext_halt_req_o = 1'b1;
        repeat (n) @(posedge sys_clk_i);
        #1 ext_halt_req_o = 1'b0;
        @(posedge sys_clk_i);
        #1;
    endtask
endmodule // drd_master_model

// [debug_resource_decoder_tb_top.sv]
// Purpose: Self-checking bench for drd_top
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Straps are changed only under reset
`timescale 1ns/1ps
module debug_resource_decoder_tb_top;
    import drd_pkg::*;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, main_ext_i = 1'b1, tpu_shared_i = 1'b0, ext_sink_i = 1'b0;
    logic ptu_present_i = 1'b1, halt_cmd_i = 1'b0, step_cmd_i = 1'b0, resume_cmd_i = 1'b0, mask_int_i = 1'b0;
    logic step_done_i = 1'b0, reg_req_i = 1'b0, acc_valid_i, ext_halt_req_i, debug_state_o, halt_o, int_mask_o;
    logic reg_grant_o, trace_en_o, dwt_trace_en_o, sink_ok_o;
    logic [31:0] acc_addr_i, lut_data_o;
    logic [DRD_SEL_W-1:0] sel_o;
    int miscompares = 0, n_tests = 0;
    drd_master_model m (.sys_clk_i, .acc_valid_o(acc_valid_i), .acc_addr_o(acc_addr_i),
        .ext_halt_req_o(ext_halt_req_i));
    drd_top i_drd_top (.sys_clk_i, .rst_n_i, .acc_valid_i, .acc_addr_i, .main_ext_i, .tpu_shared_i, .ext_sink_i,
        .ptu_present_i, .ext_halt_req_i, .halt_cmd_i, .step_cmd_i, .resume_cmd_i, .mask_int_i, .step_done_i,
        .reg_req_i, .sel_o, .lut_data_o, .debug_state_o, .halt_o, .int_mask_o, .reg_grant_o, .trace_en_o,
        .dwt_trace_en_o, .sink_ok_o);
    // 100 MHz clock
    initial forever #5 sys_clk_i = ~sys_clk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One-cycle command strobe
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge sys_clk_i);
        #1 s = 1'b0;
    endtask
    // Table entries are offsets from the table page, present flag set
    task automatic lut_chk(input logic [31:0] bases[$]);
        logic [31:0] e;
        for (int i = 0; i < 10; i++) begin
            e = i < bases.size() ? ((bases[i] - DRD_LUT_BASE) & DRD_WIN_MASK) | DRD_LUT_PRESENT : '0;
            m.access(DRD_LUT_BASE + 32'(i * 4));
            chk(lut_data_o, e);
        end
    endtask
    // Window edges, control space splits, gaps and out-of-region addresses
    task automatic t_decode;
        logic [31:0] a[20] = '{32'hE000_0000, 32'hE000_0FFC, 32'hE000_1000, 32'hE000_2FFC, 32'hE000_3000,
            32'hE000_E000, 32'hE000_ED00, 32'hE000_ED8C, 32'hE000_ED90, 32'hE000_EDF0, 32'hE000_EEFC,
            32'hE000_EFFC, 32'hE004_0000, 32'hE004_1FFC, 32'hE004_2000, 32'hE00F_EFFC, 32'hE00F_F000,
            32'hE010_0000, 32'hDFFF_FFFC, 32'h6000_0000};
        int b[20] = '{0, 0, 1, 2, -1, -1, 3, 3, 5, 4, 4, 5, 6, 7, 8, 8, 9, -1, -1, -1};
        for (int i = 0; i < 20; i++) begin
            m.access(a[i]);
            chk(sel_o, b[i] < 0 ? '0 : 32'(1) << b[i]);
        end
        m.idle();
        chk(sel_o, '0);
        chk({trace_en_o, dwt_trace_en_o, sink_ok_o}, 3'h7);
        lut_chk('{DRD_SWT_BASE, DRD_WDT_BASE, DRD_BPU_BASE, 32'hE000_E000, DRD_TPU_BASE, DRD_PTU_BASE});
        $display("t_decode done");
    endtask
    // Halt, step and resume with both interrupt settings, register grant
    task automatic t_run;
        reg_req_i = 1'b1;
        pulse(step_cmd_i);
        chk({debug_state_o, reg_grant_o}, 2'h0);
        pulse(halt_cmd_i);
        chk({debug_state_o, halt_o}, 2'h3);
        @(posedge sys_clk_i);
        #1 chk(reg_grant_o, 1'b1);
        mask_int_i = 1'b1;
        pulse(step_cmd_i);
        chk({debug_state_o, int_mask_o, reg_grant_o}, 3'h2);
        pulse(step_done_i);
        chk({debug_state_o, int_mask_o}, 2'h2);
        for (int k = 0; k < 2; k++) begin
            mask_int_i = k[0];
            pulse(resume_cmd_i);
            chk({debug_state_o, int_mask_o}, {1'b0, k[0]});
            if (k == 0) pulse(halt_cmd_i);
        end
        pulse(halt_cmd_i);
        mask_int_i = 1'b0;
        pulse(step_cmd_i);
        chk({debug_state_o, int_mask_o}, 2'h0);
        pulse(step_done_i);
        chk(debug_state_o, 1'b1);
        pulse(resume_cmd_i);
        reg_req_i = 1'b0;
        $display("t_run done");
    endtask
    // Asynchronous halt request from the far side
    task automatic t_ext_halt;
        m.ext_halt(6);
        chk(debug_state_o, 1'b1);
        pulse(resume_cmd_i);
        chk(debug_state_o, 1'b0);
        $display("t_ext_halt done");
    endtask
    // Reduced configuration: no extension, shared port, no program trace
    task automatic t_config;
        rst_n_i = 1'b0;
        main_ext_i = 1'b0;
        tpu_shared_i = 1'b1;
        ext_sink_i = 1'b1;
        ptu_present_i = 1'b0;
        @(posedge sys_clk_i);
        #1 rst_n_i = 1'b1;
        m.access(DRD_SWT_BASE);
        chk(sel_o, '0);
        m.access(DRD_TPU_BASE);
        chk(sel_o, '0);
        m.access(DRD_WDT_BASE);
        chk(sel_o, 32'(1) << DRD_SEL_WDT);
        chk({trace_en_o, dwt_trace_en_o, sink_ok_o}, 3'h1);
        lut_chk('{DRD_WDT_BASE, DRD_BPU_BASE, 32'hE000_E000});
        $display("t_config done");
    endtask
    initial begin
        repeat (6) @(posedge sys_clk_i);
        #1 rst_n_i = 1'b1;
        t_decode();
        t_run();
        t_ext_halt();
        t_config();
        tally_and_finish();
    end
    // Watchdog, far beyond the roughly 70 cycles the tests need
    initial begin
        #50000;
        miscompares++;
        tally_and_finish();
    end
endmodule // debug_resource_decoder_tb_top
